// >>> verilog/param_store_pkg.sv
package param_store_pkg;
   // parameter store geometry
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int DEPTH = 32;
   // parameter offsets
   localparam logic [4:0] OFF_BUS_ADDRESS = 5'h00;
   localparam logic [4:0] OFF_CHANNEL_LIST = 5'h01;
   localparam logic [4:0] OFF_PROX_ONE_TWO_SEL = 5'h02;
   localparam logic [4:0] OFF_PROX_THREE_SEL = 5'h03;
   localparam logic [4:0] OFF_AMBIENT_HISTORY = 5'h19;
   localparam logic [4:0] OFF_CONVERTER_OFFSET = 5'h1a;
   localparam logic [4:0] OFF_RESERVED_1B = 5'h1b;
   localparam logic [4:0] OFF_EMITTER_RECOVERY = 5'h1c;
   localparam logic [4:0] OFF_IR_RECOVERY_COUNT = 5'h1d;
   localparam logic [4:0] OFF_IR_GAIN = 5'h1e;
   localparam logic [4:0] OFF_IR_AMBIENT_RANGE_SELECT_MISC = 5'h1f;
   // reset values
   localparam logic [7:0] RST_BUS_ADDRESS = 8'h00;
   localparam logic [7:0] RST_CHANNEL_LIST = 8'h00;
   localparam logic [7:0] RST_PROX_ONE_TWO_SEL = 8'h21;
   localparam logic [7:0] RST_PROX_THREE_SEL = 8'h04;
   localparam logic [7:0] RST_OTHER = 8'h00;
   // writable-bit masks; reserved bits read zero
   localparam logic [7:0] MASK_CHANNEL_LIST = 8'h77;
   localparam logic [7:0] MASK_PROX_ONE_TWO_SEL = 8'h77;
   localparam logic [7:0] MASK_PROX_THREE_SEL = 8'h07;
   localparam logic [7:0] MASK_FULL = 8'hff;
   // channel list bit positions
   localparam int BIT_AUX_ENABLE = 6;
   localparam int BIT_IR_AMBIENT_ENABLE = 5;
   localparam int BIT_VISIBLE_AMBIENT_ENABLE = 4;
   localparam int BIT_PROX_THREE_ENABLE = 2;
   localparam int BIT_PROX_TWO_ENABLE = 1;
   localparam int BIT_PROX_ONE_ENABLE = 0;
   // emitter field positions
   localparam int LSB_PROX_ONE_EMITTERS = 0;
   localparam int LSB_PROX_TWO_EMITTERS = 4;
   localparam int LSB_PROX_THREE_EMITTERS = 0;
   localparam int EMITTER_W = 3;
   // ir gain field and range bit
   localparam int IR_GAIN_W = 3;
   localparam int BIT_IR_AMBIENT_RANGE_SELECT_SELECT = 5;
   // measurement channel codes
   localparam logic [2:0] CHAN_PROX_ONE = 3'h0;
   localparam logic [2:0] CHAN_PROX_TWO = 3'h1;
   localparam logic [2:0] CHAN_PROX_THREE = 3'h2;
endpackage

// >>> verilog/param_mem.sv
`timescale 1ns/10ps
// small parameter memory, registered read data
module param_mem #(
   parameter int AW = 5,
   parameter int DW = 8
) (
   input wire logic clk,
   input wire logic ce,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   // storage for offsets without dedicated flops
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // refuse geometries the address decode cannot serve
   if (AW < 1 || DW < 1)
   begin : g_bad_size
      $error("param_mem needs AW and DW of at least one");
   end

   // no reset: contents of these entries are undefined until written
   always_ff @(posedge clk)
   begin
      if (ce)
      begin
         if (we)
         begin
            mem[waddr] <= wdata;
         end
         rdata <= mem[raddr];
      end
   end
endmodule

// >>> verilog/sensor_param_channel_config.sv
`timescale 1ns/10ps
module sensor_param_channel_config #(
   parameter logic [7:0] BOOT_BUS_ADDRESS = 8'h2a // arbitrary default address
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic param_write_command,
   input wire logic param_read_command,
   input wire logic [4:0] param_offset,
   input wire logic [7:0] param_wdata,
   output logic [7:0] param_rdata,
   output logic param_rvalid,
   input wire logic address_change_command,
   output logic [7:0] active_bus_address,
   input wire logic meas_active,
   input wire logic [2:0] meas_channel,
   output logic aux_enable,
   output logic ir_ambient_enable,
   output logic visible_ambient_enable,
   output logic prox_one_enable,
   output logic prox_two_enable,
   output logic prox_three_enable,
   output logic channel_list_empty,
   output logic first_emitter_pin,
   output logic second_emitter_pin,
   output logic third_emitter_pin,
   output logic [7:0] emitter_recovery_time,
   output logic [2:0] ir_ambient_gain,
   output logic ir_ambient_range_select
);
   // all register state of the block
   typedef struct packed {
      logic [7:0] bus_address;
      logic [7:0] active_addr;
      logic [7:0] chan_list;
      logic [7:0] sel12;
      logic [7:0] sel3;
      logic [7:0] recovery;
      logic [7:0] ir_gain;
      logic [7:0] ir_misc;
      logic [7:0] rdata;
      logic rvalid;
      logic rd_mem;
      logic [2:0] emit;
      logic aux_en;
      logic ir_en;
      logic vis_en;
      logic p1_en;
      logic p2_en;
      logic p3_en;
      logic list_empty;
   } state_t;

   state_t s_q; // registered state
   state_t s_d; // next state
   logic [7:0] mem_rdata; // memory read data for generic offsets
   logic mem_we; // write strobe to generic storage
   logic [2:0] sel_field; // emitter field of running channel

   // offsets without dedicated flops live in the small memory
   always_comb
   begin
      mem_we = param_write_command;
      case (param_offset)
         param_store_pkg::OFF_BUS_ADDRESS,
         param_store_pkg::OFF_CHANNEL_LIST,
         param_store_pkg::OFF_PROX_ONE_TWO_SEL,
         param_store_pkg::OFF_PROX_THREE_SEL,
         param_store_pkg::OFF_EMITTER_RECOVERY,
         param_store_pkg::OFF_IR_GAIN,
         param_store_pkg::OFF_IR_AMBIENT_RANGE_SELECT_MISC: mem_we = 1'b0;
         default: mem_we = param_write_command;
      endcase
   end

   param_mem #(
      .AW(param_store_pkg::ADDR_W),
      .DW(param_store_pkg::DATA_W)
   ) u_mem (
      .clk(clk),
      .ce(ce),
      .we(mem_we),
      .waddr(param_offset),
      .wdata(param_wdata),
      .raddr(param_offset),
      .rdata(mem_rdata)
   );

   // emitter field for the channel now being measured
   always_comb
   begin
      case (meas_channel)
         param_store_pkg::CHAN_PROX_ONE: sel_field = s_q.sel12[2:0];
         param_store_pkg::CHAN_PROX_TWO: sel_field = s_q.sel12[6:4];
         param_store_pkg::CHAN_PROX_THREE: sel_field = s_q.sel3[2:0];
         default: sel_field = 3'h0; // non-proximity channels drive no emitter
      endcase
   end

   // next-state logic
   always_comb
   begin
      s_d = s_q;
      s_d.rvalid = 1'b0;
      s_d.rd_mem = 1'b0;
      // parameter write path; only the command port reaches the store
      if (param_write_command)
      begin
         case (param_offset)
            param_store_pkg::OFF_BUS_ADDRESS: s_d.bus_address = param_wdata;
            // reserved bits masked off so they read zero
            param_store_pkg::OFF_CHANNEL_LIST:
               s_d.chan_list = param_wdata & param_store_pkg::MASK_CHANNEL_LIST;
            param_store_pkg::OFF_PROX_ONE_TWO_SEL:
               s_d.sel12 = param_wdata & param_store_pkg::MASK_PROX_ONE_TWO_SEL;
            param_store_pkg::OFF_PROX_THREE_SEL:
               s_d.sel3 = param_wdata & param_store_pkg::MASK_PROX_THREE_SEL;
            param_store_pkg::OFF_EMITTER_RECOVERY: s_d.recovery = param_wdata;
            param_store_pkg::OFF_IR_GAIN: s_d.ir_gain = param_wdata;
            param_store_pkg::OFF_IR_AMBIENT_RANGE_SELECT_MISC: s_d.ir_misc = param_wdata;
            default: s_d.rvalid = 1'b0; // stored in the generic memory
         endcase
      end
      // read path: dedicated entries answer directly, others from memory next cycle
      if (param_read_command)
      begin
         s_d.rvalid = 1'b1;
         case (param_offset)
            param_store_pkg::OFF_BUS_ADDRESS: s_d.rdata = s_q.bus_address;
            param_store_pkg::OFF_CHANNEL_LIST: s_d.rdata = s_q.chan_list;
            param_store_pkg::OFF_PROX_ONE_TWO_SEL: s_d.rdata = s_q.sel12;
            param_store_pkg::OFF_PROX_THREE_SEL: s_d.rdata = s_q.sel3;
            param_store_pkg::OFF_EMITTER_RECOVERY: s_d.rdata = s_q.recovery;
            param_store_pkg::OFF_IR_GAIN: s_d.rdata = s_q.ir_gain;
            param_store_pkg::OFF_IR_AMBIENT_RANGE_SELECT_MISC: s_d.rdata = s_q.ir_misc;
            default:
            begin
               // memory data lands one cycle later; hold valid until then
               s_d.rvalid = 1'b0;
               s_d.rd_mem = 1'b1;
            end
         endcase
      end
      if (s_q.rd_mem)
      begin
         s_d.rdata = mem_rdata;
         s_d.rvalid = 1'b1;
      end
      // bus address moves only on the change command
      if (address_change_command)
      begin
         s_d.active_addr = s_q.bus_address;
      end
      // channel enables decoded from the list
      s_d.aux_en = s_q.chan_list[param_store_pkg::BIT_AUX_ENABLE];
      s_d.ir_en = s_q.chan_list[param_store_pkg::BIT_IR_AMBIENT_ENABLE];
      s_d.vis_en = s_q.chan_list[param_store_pkg::BIT_VISIBLE_AMBIENT_ENABLE];
      s_d.p1_en = s_q.chan_list[param_store_pkg::BIT_PROX_ONE_ENABLE];
      s_d.p2_en = s_q.chan_list[param_store_pkg::BIT_PROX_TWO_ENABLE];
      s_d.p3_en = s_q.chan_list[param_store_pkg::BIT_PROX_THREE_ENABLE];
      // flag so the sequencer can refuse to start on an empty list
      s_d.list_empty = (s_q.chan_list == 8'h00);
      // emitters driven only while a measurement runs
      s_d.emit = meas_active ? sel_field : 3'h0;
   end

   // state register
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         s_q.bus_address <= param_store_pkg::RST_BUS_ADDRESS;
         s_q.active_addr <= BOOT_BUS_ADDRESS;
         s_q.chan_list <= param_store_pkg::RST_CHANNEL_LIST;
         s_q.sel12 <= param_store_pkg::RST_PROX_ONE_TWO_SEL;
         s_q.sel3 <= param_store_pkg::RST_PROX_THREE_SEL;
         s_q.list_empty <= 1'b1;
      end
      else if (ce)
      begin
         s_q <= s_d;
      end
   end

   // outputs straight from flops
   assign param_rdata = s_q.rdata;
   assign param_rvalid = s_q.rvalid;
   assign active_bus_address = s_q.active_addr;
   assign aux_enable = s_q.aux_en;
   assign ir_ambient_enable = s_q.ir_en;
   assign visible_ambient_enable = s_q.vis_en;
   assign prox_one_enable = s_q.p1_en;
   assign prox_two_enable = s_q.p2_en;
   assign prox_three_enable = s_q.p3_en;
   assign channel_list_empty = s_q.list_empty;
   assign first_emitter_pin = s_q.emit[0];
   assign second_emitter_pin = s_q.emit[1];
   assign third_emitter_pin = s_q.emit[2];
   assign emitter_recovery_time = s_q.recovery;
   assign ir_ambient_gain = s_q.ir_gain[param_store_pkg::IR_GAIN_W-1:0];
   assign ir_ambient_range_select = s_q.ir_misc[param_store_pkg::BIT_IR_AMBIENT_RANGE_SELECT_SELECT];
endmodule

// >>> sim/param_cfg_chk.sv
`timescale 1ns/10ps
// port-level checks; the bench drops ce only around a single write
module param_cfg_chk (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic param_read_command,
   input wire logic param_write_command,
   input wire logic [4:0] param_offset,
   input wire logic [7:0] param_rdata,
   input wire logic param_rvalid,
   input wire logic address_change_command,
   input wire logic [7:0] active_bus_address,
   input wire logic meas_active,
   input wire logic [2:0] meas_channel,
   input wire logic aux_enable,
   input wire logic ir_ambient_enable,
   input wire logic visible_ambient_enable,
   input wire logic prox_one_enable,
   input wire logic prox_two_enable,
   input wire logic prox_three_enable,
   input wire logic channel_list_empty,
   input wire logic first_emitter_pin,
   input wire logic second_emitter_pin,
   input wire logic third_emitter_pin,
   input wire logic [7:0] emitter_recovery_time,
   input wire logic [2:0] ir_ambient_gain,
   input wire logic ir_ambient_range_select
);
   logic fast; // offsets held in flops, answered a cycle sooner
   logic wr_q; // write seen at the previous edge
   logic [4:0] woff_q; // its offset
   assign fast = param_offset inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h1c, 5'h1e, 5'h1f};
   // delayed write, so hold checks know when a change is allowed
   always_ff @(posedge clk)
   begin
      wr_q <= param_write_command;
      woff_q <= param_offset;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   rvalid_fast_a: assert property (param_read_command && fast |=> param_rvalid)
      else $error("flop read not answered");
   rvalid_slow_a: assert property (param_read_command && !fast |=> !param_rvalid ##1 param_rvalid)
      else $error("memory read not answered");
   rdata_hold_a: assert property (!param_rvalid |-> $stable(param_rdata))
      else $error("read data moved without valid");
   addr_hold_a: assert property (!$past(address_change_command) |-> $stable(active_bus_address))
      else $error("bus address moved without command");
   list_empty_a: assert property (channel_list_empty == !(aux_enable || ir_ambient_enable
      || visible_ambient_enable || prox_one_enable || prox_two_enable || prox_three_enable))
      else $error("empty flag disagrees with enables");
   emitter_idle_a: assert property (!meas_active || meas_channel > 3'h2
      |=> !(first_emitter_pin || second_emitter_pin || third_emitter_pin))
      else $error("emitter driven outside proximity");
   recovery_hold_a: assert property (!(wr_q && woff_q == 5'h1c) |-> $stable(emitter_recovery_time))
      else $error("recovery time moved");
   gain_hold_a: assert property (!(wr_q && woff_q == 5'h1e) |-> $stable(ir_ambient_gain))
      else $error("gain moved");
   range_hold_a: assert property (!(wr_q && woff_q == 5'h1f) |-> $stable(ir_ambient_range_select))
      else $error("range bit moved");
endmodule
bind sensor_param_channel_config param_cfg_chk chk (.clk, .sys_rst, .param_read_command, .param_write_command,
   .param_offset, .param_rdata, .param_rvalid, .address_change_command, .active_bus_address, .meas_active,
   .meas_channel, .aux_enable, .ir_ambient_enable, .visible_ambient_enable, .prox_one_enable, .prox_two_enable,
   .prox_three_enable, .channel_list_empty, .first_emitter_pin, .second_emitter_pin, .third_emitter_pin,
   .emitter_recovery_time, .ir_ambient_gain, .ir_ambient_range_select);

// >>> sim/host_model.sv
`timescale 1ns/10ps
// host side: strobes for parameter write, read and address change
module host_model (
   input wire logic clk,
   input wire logic [7:0] param_rdata,
   input wire logic param_rvalid,
   output logic param_write_command,
   output logic param_read_command,
   output logic [4:0] param_offset,
   output logic [7:0] param_wdata,
   output logic address_change_command
);
   initial
   begin
      param_write_command = 1'b0;
      param_read_command = 1'b0;
      param_offset = 5'h00;
      param_wdata = 8'h00;
      address_change_command = 1'b0;
   end
   // the store is reached only through these strobes
   task automatic wr(input logic [4:0] off, input logic [7:0] d);
      @(posedge clk) #1;
      param_offset = off;
      param_wdata = d;
      param_write_command = 1'b1;
      @(posedge clk) #1;
      param_write_command = 1'b0;
      // released lines show the inverse so stale values cannot pass
      param_offset = ~off;
      param_wdata = ~d;
   endtask
   // read pulse, then a bounded wait for the answer
   task automatic rd(input logic [4:0] off, output logic [7:0] d);
      @(posedge clk) #1;
      param_offset = off;
      param_read_command = 1'b1;
      @(posedge clk) #1;
      param_read_command = 1'b0;
      param_offset = ~off;
      repeat (4)
      begin
         if (param_rvalid === 1'b1)
         begin
            d = param_rdata;
            break;
         end
         @(posedge clk) #1;
      end
   endtask
   // one-cycle address change pulse
   task automatic chg;
      @(posedge clk) #1;
      address_change_command = 1'b1;
      @(posedge clk) #1;
      address_change_command = 1'b0;
   endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_top;
   logic clk, sys_rst, ce, meas_active, param_write_command, param_read_command, address_change_command;
   logic param_rvalid, aux_enable, ir_ambient_enable, visible_ambient_enable, prox_one_enable, prox_two_enable;
   logic prox_three_enable, channel_list_empty, first_emitter_pin, second_emitter_pin, third_emitter_pin;
   logic ir_ambient_range_select;
   logic [2:0] meas_channel, ir_ambient_gain, cv, pins_seen;
   logic [4:0] param_offset;
   logic [7:0] param_wdata, param_rdata, active_bus_address, emitter_recovery_time, rd_data, exp, en_seen;
   int failures = 0;
   int samples_checked = 0;
   sensor_param_channel_config uut (.clk, .sys_rst, .ce, .param_write_command, .param_read_command,
      .param_offset, .param_wdata, .param_rdata, .param_rvalid, .address_change_command, .active_bus_address,
      .meas_active, .meas_channel, .aux_enable, .ir_ambient_enable, .visible_ambient_enable, .prox_one_enable,
      .prox_two_enable, .prox_three_enable, .channel_list_empty, .first_emitter_pin, .second_emitter_pin,
      .third_emitter_pin, .emitter_recovery_time, .ir_ambient_gain, .ir_ambient_range_select);
   host_model host (.clk, .param_rdata, .param_rvalid, .param_write_command, .param_read_command,
      .param_offset, .param_wdata, .address_change_command);
   // 100 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic pulse_reset;
      sys_rst = 1'b1;
      repeat (4) @(posedge clk);
      #1 sys_rst = 1'b0;
   endtask
   task automatic rdchk(input logic [4:0] off, input logic [7:0] e);
      host.rd(off, rd_data);
      `CHK("param_rdata", e, rd_data)
   endtask
   task automatic report_and_stop;
      $display("mismatches %0d, checks %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // cut a hang short; the whole run needs well under this
   initial
   begin
      #100000;
      failures++;
      report_and_stop();
   end
   initial
   begin
      ce = 1'b1;
      meas_active = 1'b0;
      meas_channel = 3'h0;
      pulse_reset();
      rdchk(5'h00, 8'h00);
      rdchk(5'h02, 8'h21);
      rdchk(5'h03, 8'h04);
      `CHK("boot address", 8'h2a, active_bus_address)
      // walk one bit through the list; reserved bits must drop
      for (int i = 0; i < 8; i++)
      begin
         host.wr(5'h01, 8'h01 << i);
         @(posedge clk) #1;
         exp = (8'h01 << i) & 8'h77;
         en_seen = {1'b0, aux_enable, ir_ambient_enable, visible_ambient_enable, 1'b0, prox_three_enable,
            prox_two_enable, prox_one_enable};
         `CHK("enables", exp, en_seen)
         `CHK("list empty", exp == 8'h00, channel_list_empty)
         rdchk(5'h01, exp);
      end
      host.wr(5'h01, 8'h07);
      // every emitter code in each field, reserved bits set
      for (int c = 0; c < 8; c++)
      begin
         cv = c[2:0];
         host.wr(5'h02, {1'b1, cv + 3'h1, 1'b1, cv});
         host.wr(5'h03, {5'h1f, cv + 3'h2});
         rdchk(5'h02, {1'b0, cv + 3'h1, 1'b0, cv});
         rdchk(5'h03, {5'h00, cv + 3'h2});
         for (int m = 0; m < 4; m++)
         begin
            meas_active = 1'b1;
            meas_channel = m[2:0];
            @(posedge clk) #1;
            pins_seen = {third_emitter_pin, second_emitter_pin, first_emitter_pin};
            `CHK("emitters", (m < 3) ? cv + m[2:0] : 3'h0, pins_seen)
         end
         meas_active = 1'b0;
      end
      // proximity code but no measurement running: all emitters off
      meas_channel = 3'h0;
      @(posedge clk) #1;
      pins_seen = {third_emitter_pin, second_emitter_pin, first_emitter_pin};
      `CHK("idle emitters", 3'h0, pins_seen)
      host.wr(5'h00, 8'h5c);
      @(posedge clk) #1;
      `CHK("address before command", 8'h2a, active_bus_address)
      host.chg();
      `CHK("address after command", 8'h5c, active_bus_address)
      host.wr(5'h1c, 8'hc3);
      `CHK("recovery", 8'hc3, emitter_recovery_time)
      host.wr(5'h1e, 8'hfd);
      `CHK("gain", 3'h5, ir_ambient_gain)
      host.wr(5'h1f, 8'h20);
      `CHK("range", 1'b1, ir_ambient_range_select)
      host.wr(5'h1f, 8'h00);
      `CHK("range", 1'b0, ir_ambient_range_select)
      host.wr(5'h19, 8'h99);
      rdchk(5'h19, 8'h99);
      host.wr(5'h1b, 8'h00);
      rdchk(5'h1b, 8'h00);
      // clock enable low: a write must not land
      ce = 1'b0;
      host.wr(5'h1c, 8'h3c);
      ce = 1'b1;
      `CHK("frozen recovery", 8'hc3, emitter_recovery_time)
      rdchk(5'h1c, 8'hc3);
      pulse_reset();
      rdchk(5'h02, 8'h21);
      `CHK("address after reset", 8'h2a, active_bus_address)
      report_and_stop();
   end
endmodule
